/* src/mic_pkg.sv */
// Summary of operation
// - A source trigger pulse sets that source's request flag.
// - A flag vectors only while its own enable bit is set.
// - Global enable at zero suppresses every interrupt.
// - Taking an interrupt pushes the next PC and loads the vector on the same edge.
// - Return-from-interrupt pops the saved PC back, except when a take falls in the same cycle.
// - Servicing any interrupt clears the global enable.
// - Requests while globally blocked still set their flags and stay pending.
// - No acknowledge while the stack is full.
// - Hardware setting any clear source flag wakes the device from sleep or idle.
// - Pin flag sets on the edge chosen by its edge-select field.
// - Pin acts as interrupt only if enabled, selected and an input.
// - Servicing a pin interrupt clears its flag and global enable.
// - Pull-up selection stays in effect while used as interrupt.
// - Edge select offers rising, falling, both or disabled per pin.
// - Some sources own vectors; grouped sources share one vector.
// - First control register: pin and comparator flags, enables, global bit.
// - Second register: eeprom, conversion, low-voltage, serial flags and enables.
// - Third register: timer match flags 7..4, enables 3..0.
// - Fourth register: grouped, comparator, time base flags and enables.
// - Grouped register: uart and timer b flags 6..4, enables 2..0.
// - Edge code: 00 off, 01 rise, 10 fall, 11 both.
// - Grouped flag sets when a grouped source whose enable bit is set pulses.
// - Servicing the grouped vector clears the grouped flag, not the grouped source flags.
package mic_pkg;
    localparam logic [11:0] ADDR_CTRL0 = 12'h000;
    localparam logic [11:0] ADDR_CTRL1 = 12'h004;
    localparam logic [11:0] ADDR_CTRL2 = 12'h008;
    localparam logic [11:0] ADDR_CTRL3 = 12'h00C;
    localparam logic [11:0] ADDR_GROUP = 12'h010;
    localparam logic [11:0] ADDR_EDGE = 12'h014;
    localparam logic [11:0] ADDR_STAT = 12'h018;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] CTRL0_MASK = 8'h7F;
    localparam logic [7:0] GROUP_MASK = 8'h77;
    localparam logic [7:0] EDGE_MASK = 8'h0F;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam int GLOBAL_BIT = 0;
    localparam int FLAG_POS = 4;
    localparam int GROUP_FLAG_BIT = 7;
    localparam int NUM_VEC = 14;
    localparam int VEC_W = 4;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 4;
endpackage : mic_pkg

/* src/mic_stack_if.sv */
`timescale 1ns/1ps
interface mic_stack_if;
    import mic_pkg::*;
    logic push;
    logic pop;
    logic [PC_W-1:0] push_pc;
    logic [PC_W-1:0] top_pc;
    logic full;
    logic [SP_W-1:0] depth;
    modport ctrl (output push, output pop, output push_pc, input top_pc, input full,
        input depth);
    modport stk (input push, input pop, input push_pc, output top_pc, output full,
        output depth);
endinterface : mic_stack_if

/* src/mic_stack.sv */
`timescale 1ns/1ps
module mic_stack
    import mic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    mic_stack_if.stk s
);
    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_ff;
    logic [SP_W-1:0] top_idx;

    assign top_idx = sp_ff - 4'h1;
    assign s.full = (sp_ff == SP_W'(STACK_DEPTH));
    assign s.depth = sp_ff;
    assign s.top_pc = (sp_ff == 4'h0) ? '0 : mem[top_idx[2:0]];

    always_ff @(posedge i_core_clk) begin
        if (s.push && !s.full) begin
            mem[sp_ff[2:0]] <= s.push_pc;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sp_ff <= '0;
        end else if (s.push && !s.full) begin
            sp_ff <= sp_ff + 4'h1;
        end else if (s.pop && sp_ff != 4'h0) begin
            sp_ff <= sp_ff - 4'h1;
        end
    end
endmodule : mic_stack

/* src/mic_irq_ctrl.sv */
`timescale 1ns/1ps
module mic_irq_ctrl
    import mic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_ext_pin_a,
    input wire logic i_ext_pin_b,
    input wire logic [1:0] i_pin_func_sel,
    input wire logic [1:0] i_pin_dir_in,
    input wire logic [1:0] i_pin_pullup_sel,
    output logic [1:0] o_pin_pullup_en,
    input wire logic i_line_comparator_a,
    input wire logic i_line_comparator_b,
    input wire logic i_eeprom_done,
    input wire logic i_conversion_done,
    input wire logic i_low_voltage,
    input wire logic i_serial_module,
    input wire logic i_std_timer_a_match_a,
    input wire logic i_std_timer_a_match_p,
    input wire logic i_periodic_timer_match_a,
    input wire logic i_periodic_timer_match_p,
    input wire logic i_time_base_a,
    input wire logic i_time_base_b,
    input wire logic i_async_serial,
    input wire logic i_std_timer_b_match_a,
    input wire logic i_std_timer_b_match_p,
    input wire logic i_instr_boundary,
    input wire logic [PC_W-1:0] i_next_pc,
    input wire logic i_return_from_interrupt_instr,
    output logic o_irq_take,
    output logic [VEC_W-1:0] o_irq_vector,
    output logic [PC_W-1:0] o_return_pc,
    output logic o_return_valid,
    output logic o_wake
);
    typedef enum logic [VEC_W-1:0] {
        V_PIN_A, V_PIN_B, V_CMP_A, V_SERIAL, V_LOWV, V_CONV, V_EEPROM,
        V_TMR_AP, V_TMR_AA, V_PTM_P, V_PTM_A, V_TB_A, V_TB_B, V_CMP_B, V_GROUP
    } mic_vec_e;

    logic [7:0] ctrl0_ff, ctrl1_ff, ctrl2_ff, ctrl3_ff, group_ff;
    logic [3:0] edge_ff;
    logic [1:0] pin_prev_ff;
    logic take_ff;
    logic [VEC_W-1:0] vec_ff;
    logic [PC_W-1:0] ret_pc_ff;
    logic ret_ff;
    logic wake_ff;
    logic [7:0] nxt_ctrl0, nxt_ctrl1, nxt_ctrl2, nxt_ctrl3, nxt_group;
    logic [1:0] pin_now;
    logic [1:0] pin_edge;
    logic [NUM_VEC:0] req;
    logic [NUM_VEC:0] flags;
    logic any_req;
    logic [VEC_W-1:0] sel;
    logic wr_en;
    logic take;
    logic [3:0] c1_set, c2_set;
    logic [2:0] grp_set;

    mic_stack_if stk_bus ();

    mic_stack u_stack (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .s(stk_bus.stk)
    );

    assign wr_en = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;

    assign o_pin_pullup_en = i_pin_pullup_sel;

    assign pin_now = {i_ext_pin_b, i_ext_pin_a};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic rise, fall, act, hit;
            assign rise = pin_now[g] && !pin_prev_ff[g];
            assign fall = !pin_now[g] && pin_prev_ff[g];
            assign act = ctrl0_ff[2 + g] && i_pin_func_sel[g] && i_pin_dir_in[g];
            always_comb begin
                case (edge_ff[2*g +: 2])
                    EDGE_RISE: hit = act && rise;
                    EDGE_FALL: hit = act && fall;
                    EDGE_BOTH: hit = act && (rise || fall);
                    default: hit = 1'b0;
                endcase
            end
            assign pin_edge[g] = hit;
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_prev_ff <= '0;
        end else begin
            pin_prev_ff <= pin_now;
        end
    end

    assign c1_set = {i_eeprom_done, i_conversion_done, i_low_voltage, i_serial_module};
    assign c2_set = {i_std_timer_a_match_a, i_std_timer_a_match_p,
        i_periodic_timer_match_a, i_periodic_timer_match_p};
    assign grp_set = {i_async_serial, i_std_timer_b_match_a, i_std_timer_b_match_p};

    // vector order sets priority, pins first
    assign flags = {ctrl3_ff[7], ctrl3_ff[6], ctrl3_ff[5], ctrl3_ff[4], ctrl2_ff[5],
        ctrl2_ff[4], ctrl2_ff[7], ctrl2_ff[6], ctrl1_ff[7], ctrl1_ff[6],
        ctrl1_ff[5], ctrl1_ff[4], ctrl0_ff[4], ctrl0_ff[6], ctrl0_ff[5]};
    assign req = flags & {ctrl3_ff[3], ctrl3_ff[2], ctrl3_ff[1], ctrl3_ff[0], ctrl2_ff[1],
        ctrl2_ff[0], ctrl2_ff[3], ctrl2_ff[2], ctrl1_ff[3], ctrl1_ff[2],
        ctrl1_ff[1], ctrl1_ff[0], ctrl0_ff[1], ctrl0_ff[3], ctrl0_ff[2]};

    always_comb begin
        sel = '0;
        any_req = 1'b0;
        for (int i = NUM_VEC; i >= 0; i--) begin
            if (req[i]) begin
                sel = VEC_W'(i);
                any_req = 1'b1;
            end
        end
    end

    // global gate and stack full block
    assign take = any_req && ctrl0_ff[GLOBAL_BIT] && !stk_bus.full && i_instr_boundary;

    assign stk_bus.push = take;
    assign stk_bus.push_pc = i_next_pc;
    // A return that meets a take is dropped; the core must repeat it
    // pop on return
    assign stk_bus.pop = i_return_from_interrupt_instr && !take;

    always_comb begin
        nxt_ctrl0 = ctrl0_ff;
        if (wr_en && i_paddr == ADDR_CTRL0) begin
            nxt_ctrl0 = i_pwdata[7:0] & CTRL0_MASK;
        end
        if (take) begin
            nxt_ctrl0[GLOBAL_BIT] = 1'b0;
            if (sel == V_PIN_A) begin
                nxt_ctrl0[5] = 1'b0;
            end
            if (sel == V_PIN_B) begin
                nxt_ctrl0[6] = 1'b0;
            end
            if (sel == V_CMP_A) begin
                nxt_ctrl0[4] = 1'b0;
            end
        end
        // Set wins over clear
        if (pin_edge[0]) begin
            nxt_ctrl0[5] = 1'b1;
        end
        if (pin_edge[1]) begin
            nxt_ctrl0[6] = 1'b1;
        end
        if (i_line_comparator_a) begin
            nxt_ctrl0[4] = 1'b1;
        end
    end

    always_comb begin
        nxt_ctrl1 = ctrl1_ff;
        nxt_ctrl2 = ctrl2_ff;
        if (wr_en && i_paddr == ADDR_CTRL1) begin
            nxt_ctrl1 = i_pwdata[7:0];
        end
        if (wr_en && i_paddr == ADDR_CTRL2) begin
            nxt_ctrl2 = i_pwdata[7:0];
        end
        if (take) begin
            case (sel)
                V_SERIAL: nxt_ctrl1[4] = 1'b0;
                V_LOWV: nxt_ctrl1[5] = 1'b0;
                V_CONV: nxt_ctrl1[6] = 1'b0;
                V_EEPROM: nxt_ctrl1[7] = 1'b0;
                V_TMR_AP: nxt_ctrl2[6] = 1'b0;
                V_TMR_AA: nxt_ctrl2[7] = 1'b0;
                V_PTM_P: nxt_ctrl2[4] = 1'b0;
                V_PTM_A: nxt_ctrl2[5] = 1'b0;
                default: ;
            endcase
        end
        nxt_ctrl1[7:4] = nxt_ctrl1[7:4] | c1_set;
        nxt_ctrl2[7:4] = nxt_ctrl2[7:4] | c2_set;
    end

    always_comb begin
        nxt_ctrl3 = ctrl3_ff;
        nxt_group = group_ff;
        if (wr_en && i_paddr == ADDR_CTRL3) begin
            nxt_ctrl3 = i_pwdata[7:0];
        end
        if (wr_en && i_paddr == ADDR_GROUP) begin
            nxt_group = i_pwdata[7:0] & GROUP_MASK;
        end
        if (take) begin
            case (sel)
                V_TB_A: nxt_ctrl3[4] = 1'b0;
                V_TB_B: nxt_ctrl3[5] = 1'b0;
                V_CMP_B: nxt_ctrl3[6] = 1'b0;
                V_GROUP: nxt_ctrl3[GROUP_FLAG_BIT] = 1'b0;
                default: ;
            endcase
        end
        nxt_group[6:4] = nxt_group[6:4] | grp_set;
        nxt_ctrl3[4] = nxt_ctrl3[4] | i_time_base_a;
        nxt_ctrl3[5] = nxt_ctrl3[5] | i_time_base_b;
        nxt_ctrl3[6] = nxt_ctrl3[6] | i_line_comparator_b;
        // Grouped flag only raised by an enabled grouped source
        if (|(grp_set & group_ff[2:0])) begin
            nxt_ctrl3[GROUP_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl0_ff <= RST_REG;
        end else begin
            ctrl0_ff <= nxt_ctrl0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl1_ff <= RST_REG;
        end else begin
            ctrl1_ff <= nxt_ctrl1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl2_ff <= RST_REG;
        end else begin
            ctrl2_ff <= nxt_ctrl2;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ctrl3_ff <= RST_REG;
        end else begin
            ctrl3_ff <= nxt_ctrl3;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            group_ff <= RST_REG;
        end else begin
            group_ff <= nxt_group;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            edge_ff <= '0;
        end else if (wr_en && i_paddr == ADDR_EDGE) begin
            edge_ff <= i_pwdata[3:0] & EDGE_MASK[3:0];
        end
    end

    // A flag preset by software stays quiet, which masks its wake-up
    // wake when hardware sets a clear flag
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= |(pin_edge & ~{ctrl0_ff[6], ctrl0_ff[5]})
                || |(c1_set & ~ctrl1_ff[7:4])
                || |(c2_set & ~ctrl2_ff[7:4])
                || |(grp_set & ~group_ff[6:4])
                || (i_line_comparator_a && !ctrl0_ff[4])
                || (i_time_base_a && !ctrl3_ff[4])
                || (i_time_base_b && !ctrl3_ff[5])
                || (i_line_comparator_b && !ctrl3_ff[6]);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            take_ff <= 1'b0;
            vec_ff <= '0;
            ret_ff <= 1'b0;
            ret_pc_ff <= '0;
        end else begin
            take_ff <= take;
            ret_ff <= stk_bus.pop;
            if (take) begin
                vec_ff <= sel;
            end
            if (stk_bus.pop) begin
                ret_pc_ff <= stk_bus.top_pc;
            end
        end
    end

    assign o_irq_take = take_ff;
    assign o_irq_vector = vec_ff;
    assign o_return_valid = ret_ff;
    assign o_return_pc = ret_pc_ff;
    assign o_wake = wake_ff;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_prdata <= '0;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                ADDR_CTRL0: o_prdata <= {24'h0, ctrl0_ff};
                ADDR_CTRL1: o_prdata <= {24'h0, ctrl1_ff};
                ADDR_CTRL2: o_prdata <= {24'h0, ctrl2_ff};
                ADDR_CTRL3: o_prdata <= {24'h0, ctrl3_ff};
                ADDR_GROUP: o_prdata <= {24'h0, group_ff};
                ADDR_EDGE: o_prdata <= {28'h0, edge_ff};
                ADDR_STAT: o_prdata <= {27'h0, stk_bus.full, stk_bus.depth};
                default: o_prdata <= '0;
            endcase
        end
    end
endmodule : mic_irq_ctrl

/* tb/mic_irq_ctrl_assertions.sv */
`timescale 1ns/1ps
module mic_irq_chk
    import mic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [1:0] i_pin_pullup_sel,
    input wire logic [1:0] o_pin_pullup_en,
    input wire logic i_instr_boundary,
    input wire logic i_return_from_interrupt_instr,
    input wire logic o_irq_take,
    input wire logic [VEC_W-1:0] o_irq_vector,
    input wire logic o_return_valid
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic armed_ff;
    logic [SP_W-1:0] depth_ff;
    // Last written global bit; a take consumes it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            armed_ff <= 1'b0;
        end else if (i_psel && i_penable && i_pwrite && i_paddr == ADDR_CTRL0) begin
            armed_ff <= i_pwdata[GLOBAL_BIT];
        end else if (o_irq_take) begin
            armed_ff <= 1'b0;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            depth_ff <= '0;
        end else begin
            depth_ff <= depth_ff + SP_W'(o_irq_take) - SP_W'(o_return_valid);
        end
    end
    a_apb_zero_wait: assert property (i_psel && i_penable |-> o_pready && !o_pslverr)
        else $error("apb access stalled or erred");
    a_pullup_kept: assert property (o_pin_pullup_en == i_pin_pullup_sel)
        else $error("pull-up selection lost");
    a_take_boundary: assert property (o_irq_take |-> $past(i_instr_boundary))
        else $error("take off an instruction boundary");
    a_take_needs_global: assert property (o_irq_take |-> $past(armed_ff))
        else $error("take while global enable clear");
    a_take_stack_room: assert property (o_irq_take |-> depth_ff < SP_W'(STACK_DEPTH))
        else $error("take with stack full");
    a_vector_range: assert property (o_irq_take |-> o_irq_vector <= 4'hE)
        else $error("vector out of range");
    a_take_single: assert property (o_irq_take |=> !o_irq_take)
        else $error("second take without re-arm");
    a_return_answer: assert property (
        i_return_from_interrupt_instr |=> o_return_valid || o_irq_take)
        else $error("return not answered");
    a_return_cause: assert property (o_return_valid |-> $past(i_return_from_interrupt_instr))
        else $error("return without request");
endmodule : mic_irq_chk

bind mic_irq_ctrl mic_irq_chk mic_irq_chk_i (.i_core_clk, .i_sys_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_pin_pullup_sel, .o_pin_pullup_en,
    .i_instr_boundary, .i_return_from_interrupt_instr, .o_irq_take, .o_irq_vector,
    .o_return_valid);

/* tb/mic_core_model.sv */
`timescale 1ns/1ps
module mic_core_model
    import mic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_allow,
    input wire logic i_irq_take,
    input wire logic i_return_valid,
    output logic o_boundary,
    output logic [PC_W-1:0] o_next_pc,
    output logic [PC_W-1:0] o_top_pc
);
    logic [PC_W-1:0] stk [0:15];
    logic [3:0] sp;
    // Multi-cycle instructions leave gaps between boundaries
    assign o_boundary = i_allow && (o_next_pc[1:0] != 2'h3);
    assign o_top_pc = stk[sp - 4'h1];
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_next_pc <= 13'h0100;
            sp <= 4'h0;
        end else begin
            o_next_pc <= o_next_pc + 13'h0001;
            if (i_irq_take) begin
                stk[sp] <= o_next_pc - 13'h0001;
                sp <= sp + 4'h1;
            end
            if (i_return_valid) begin
                sp <= sp - 4'h1;
            end
        end
    end
endmodule : mic_core_model

/* tb/tb_mcu_interrupt_controller.sv */
`timescale 1ns/1ps
module tb_mcu_interrupt_controller;
    import mic_pkg::*;
    localparam logic [11:0] AD [0:5] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2, ADDR_CTRL3,
        ADDR_GROUP, ADDR_EDGE};
    localparam logic [7:0] MK [0:5] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h0F};
    localparam logic [7:0] FL [0:4] = '{8'h10, 8'hF0, 8'hF0, 8'hF0, 8'h77};
    localparam int RI [0:14] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3};
    localparam int BI [0:14] = '{5, 6, 4, 4, 5, 6, 7, 6, 7, 4, 5, 4, 5, 6, 7};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, allow = 1'b0, ret = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [1:0] pin = '0, cfg = 2'h3, fsel = 2'h3, pup = '0;
    logic [16:0] src = '0;
    logic pready, take, rvalid, wake, bnd, got;
    logic [31:0] prdata, rd;
    logic [VEC_W-1:0] vec;
    logic [PC_W-1:0] npc, rpc, top;
    logic [7:0] ex [0:3];
    int err_total = 0, comparisons = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    mic_irq_ctrl mic_irq_ctrl_i (
        .i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(), .i_ext_pin_a(pin[0]), .i_ext_pin_b(pin[1]), .i_pin_func_sel(fsel),
        .i_pin_dir_in(cfg), .i_pin_pullup_sel(pup), .o_pin_pullup_en(),
        .i_line_comparator_a(src[2]), .i_serial_module(src[3]), .i_low_voltage(src[4]),
        .i_conversion_done(src[5]), .i_eeprom_done(src[6]), .i_std_timer_a_match_p(src[7]),
        .i_std_timer_a_match_a(src[8]), .i_periodic_timer_match_p(src[9]),
        .i_periodic_timer_match_a(src[10]), .i_time_base_a(src[11]), .i_time_base_b(src[12]),
        .i_line_comparator_b(src[13]), .i_async_serial(src[14]),
        .i_std_timer_b_match_a(src[15]), .i_std_timer_b_match_p(src[16]),
        .i_instr_boundary(bnd), .i_next_pc(npc), .i_return_from_interrupt_instr(ret),
        .o_irq_take(take), .o_irq_vector(vec), .o_return_pc(rpc), .o_return_valid(rvalid),
        .o_wake(wake));
    mic_core_model mic_core_model_i (.i_core_clk(clk), .i_sys_rst(rst), .i_allow(allow),
        .i_irq_take(take), .i_return_valid(rvalid), .o_boundary(bnd), .o_next_pc(npc),
        .o_top_pc(top));
    task check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rchk
    task wait_take(input int n);
        got = 1'b0;
        repeat (n) begin
            @(negedge clk);
            if (take === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
    endtask : wait_take
    task pulse_wake(input logic [16:0] s);
        @(posedge clk);
        src <= s;
        @(posedge clk);
        src <= '0;
        got = 1'b0;
        repeat (3) begin
            @(negedge clk);
            if (wake === 1'b1) got = 1'b1;
        end
    endtask : pulse_wake
    task edge_try(input int p, input logic l, input logic e);
        @(posedge clk);
        pin[p] <= l;
        repeat (3) @(posedge clk);
        rchk(ADDR_CTRL0, 32'h0C | (32'(e) << (5 + p)));
        apb(1'b1, ADDR_CTRL0, 32'h0C);
    endtask : edge_try
    task do_ret;
        logic [PC_W-1:0] e;
        // The model pops one edge after the design; read its top before driving the return
        @(negedge clk);
        e = top;
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        @(negedge clk);
        check({rvalid, rpc}, {1'b1, e});
    endtask : do_ret
    task conclude;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rchk(AD[i], 32'h0);
            apb(1'b1, AD[i], 32'hFFFFFFFF);
            rchk(AD[i], {24'h0, MK[i]});
            apb(1'b1, AD[i], 32'h0);
        end
        apb(1'b1, 12'h01C, 32'hFF);
        rchk(12'h01C, 32'h0);
        // Last passes keep both edges but drop the input direction, then the function
        apb(1'b1, ADDR_CTRL0, 32'h0C);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 6; c++) begin
                cfg <= (c == 4) ? 2'h0 : 2'h3;
                fsel <= (c == 5) ? 2'h0 : 2'h3;
                pup <= c[1:0];
                apb(1'b1, ADDR_EDGE, 32'((c >= 4) ? 3 : c) << (2 * p));
                edge_try(p, 1'b1, c < 4 && c[0]);
                edge_try(p, 1'b0, c < 4 && c[1]);
            end
        end
        cfg <= 2'h3;
        fsel <= 2'h3;
        apb(1'b1, ADDR_CTRL0, 32'h0);
        apb(1'b1, ADDR_GROUP, 32'h07);
        pulse_wake(17'h1FFFC);
        check(got, 1'b1);
        // Eeprom flag is now preset, so its next pulse must stay quiet
        pulse_wake(17'h00040);
        check(got, 1'b0);
        for (int i = 0; i < 5; i++) rchk(AD[i], {24'h0, FL[i]});
        apb(1'b1, ADDR_CTRL0, 32'h71);
        allow <= 1'b1;
        wait_take(12);
        check(got, 1'b0);
        apb(1'b1, ADDR_CTRL0, 32'h7E);
        for (int i = 1; i < 4; i++) apb(1'b1, AD[i], 32'hFF);
        wait_take(12);
        check(got, 1'b0);
        ex = '{8'h7E, 8'hFF, 8'hFF, 8'hFF};
        for (int v = 0; v < 15; v++) begin
            ex[0][0] = 1'b1;
            apb(1'b1, ADDR_CTRL0, {24'h0, ex[0]});
            if (v >= STACK_DEPTH) begin
                wait_take(12);
                check(got, 1'b0);
                do_ret;
            end
            wait_take(60);
            check({got, vec}, {1'b1, 4'(v)});
            ex[0][0] = 1'b0;
            ex[RI[v]][BI[v]] = 1'b0;
            rchk(ADDR_CTRL0, {24'h0, ex[0]});
            rchk(AD[RI[v]], {24'h0, ex[RI[v]]});
        end
        rchk(ADDR_GROUP, 32'h77);
        repeat (8) do_ret;
        conclude;
    end
endmodule : tb_mcu_interrupt_controller
